// file: common/lfm_pkg.sv
// constants for the laser fault monitor
package lfm_pkg;
	// ****************************************
	// status byte layout
	// ****************************************
	localparam int FLAG_SWITCH_BIT = 7;
	localparam int FLAG_BIAS_BIT = 6;
	localparam int FLAG_SUPPLY_BIT = 5;
	localparam int FLAG_DIFFUSER_BIT = 4;
	localparam int FLAG_OVERCURRENT_BIT = 3;
	localparam logic [4:0] FLAGS_RESET = 5'h00;
	// arbitrary version value
	localparam logic [2:0] VERSION_CODE = 3'h5;
	// ****************************************
	// global reset command
	// ****************************************
	localparam logic [7:0] GLOBAL_RESET_CMD = 8'h01;
	// ****************************************
	// overcurrent limits, code 7 is off
	// ****************************************
	localparam logic [2:0] OVERCURRENT_LIMIT_SEL_OFF = 3'h7;
	localparam logic [8:0] OC_LIMIT_0 = 9'h0E9;
	localparam logic [8:0] OC_LIMIT_1 = 9'h0C8;
	localparam logic [8:0] OC_LIMIT_2 = 9'h0A7;
	localparam logic [8:0] OC_LIMIT_3 = 9'h085;
	localparam logic [8:0] OC_LIMIT_4 = 9'h06B;
	localparam logic [8:0] OC_LIMIT_5 = 9'h050;
	localparam logic [8:0] OC_LIMIT_6 = 9'h035;
	// ****************************************
	// photodiode margins
	// ****************************************
	localparam logic [1:0] SEL2_OFF = 2'h3;
	localparam logic [11:0] DIF_OFFSET_0 = 12'h080;
	localparam logic [11:0] DIF_OFFSET_1 = 12'h040;
	localparam logic [11:0] DIF_OFFSET_2 = 12'h020;
	localparam logic [11:0] BIAS_CHECK_MARGIN = 12'h040;
	localparam logic [11:0] SW_WINDOW_0 = 12'h040;
	localparam logic [11:0] SW_WINDOW_1 = 12'h080;
	localparam logic [11:0] SW_WINDOW_2 = 12'h100;
endpackage : lfm_pkg

// file: verilog/lfm_calib_check.sv
// calibration-time fault detectors
module lfm_calib_check
	import lfm_pkg::*;
(
	// photodiode results
	input wire logic [9:0] bias_high_result,
	input wire logic [9:0] bias_low_result,
	input wire logic [9:0] switch_high_result,
	input wire logic [9:0] switch_low_result,
	input wire logic [9:0] background_value,
	input wire logic [9:0] photodiode_target,
	input wire logic [9:0] bias_check_result,
	input wire logic [9:0] switch_check_result,
	// calculation status
	input wire logic bias_calc_overflow,
	input wire logic switch_calc_overflow,
	input wire logic threshold_negative,
	input wire logic switch_code_negative,
	// selects
	input wire logic [1:0] diffuser_check_sel,
	input wire logic bias_check_disable,
	input wire logic [1:0] switch_check_window_sel,
	// results
	output logic bias_fault,
	output logic switch_fault,
	output logic diffuser_fault
);
	logic [11:0] bg;
	logic [11:0] target_sum;
	logic [11:0] sw_chk;
	logic [11:0] deviation;
	logic [11:0] dif_offset;
	logic [11:0] sw_window;
	logic bias_op_err;
	logic switch_op_err;

	assign bg = {2'h0, background_value};
	assign target_sum = {2'h0, photodiode_target} + bg;
	assign sw_chk = {2'h0, switch_check_result};
	assign deviation = (sw_chk >= target_sum) ? (sw_chk - target_sum) : (target_sum - sw_chk);

	always_comb begin
		case (diffuser_check_sel)
			2'h0: dif_offset = DIF_OFFSET_0;
			2'h1: dif_offset = DIF_OFFSET_1;
			default: dif_offset = DIF_OFFSET_2;
		endcase
	end

	always_comb begin
		case (switch_check_window_sel)
			2'h0: sw_window = SW_WINDOW_0;
			2'h1: sw_window = SW_WINDOW_1;
			default: sw_window = SW_WINDOW_2;
		endcase
	end

	// ****************************************
	// detectors
	// ****************************************
	assign bias_op_err = (bias_high_result <= bias_low_result) || bias_calc_overflow;
	assign switch_op_err = (switch_high_result <= switch_low_result) || switch_calc_overflow;

	always_comb begin
		bias_fault = bias_op_err;
		if (!bias_check_disable) begin
			bias_fault = bias_op_err || threshold_negative
				|| ({2'h0, bias_check_result} > bg + BIAS_CHECK_MARGIN);
		end
	end

	always_comb begin
		switch_fault = switch_op_err;
		if (switch_check_window_sel != SEL2_OFF) begin
			switch_fault = switch_op_err || (deviation > sw_window)
				|| switch_code_negative;
		end
	end

	assign diffuser_fault = (diffuser_check_sel != SEL2_OFF) && (sw_chk < bg + dif_offset);
endmodule : lfm_calib_check

// file: verilog/lfm_monitor.sv
// emergency detection and laser drive control
// Operation
// - enabled fault cuts laser, pulls emergency, flags
// - five flags in status bits 7..3
// - flags sticky until dummy write or reset
// - all detectors selectable except supply monitor and high minus low checks
// - supply below low threshold raises fault
// - supply above high threshold releases cut-off
// - overcurrent when bias[7:2] plus switch exceeds limit
// - limit codes 233..53, code seven disables
// - clamp setting limits current, keeps emergency high
// - diffuser fault when check below background plus offset
// - bias check: negative threshold or high reading
// - bias check off: no fault, negative becomes zero
// - bias high minus low nonpositive or overflow
// - switch high minus low nonpositive or overflow
// - switch check outside window around target plus background
// - negative switch code faults while check enabled
// - calibration fault: cut, or fixed codes by setting
// - dummy status write clears sticky flags
// - global reset command clears unless blocked
module lfm_monitor
	import lfm_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// supply comparators
	input wire logic supply_low,
	input wire logic supply_high,
	// computed drive codes
	input wire logic [7:0] computed_bias_code,
	input wire logic [7:0] computed_switch_code,
	input wire logic threshold_negative,
	input wire logic switch_code_negative,
	input wire logic bias_calc_overflow,
	input wire logic switch_calc_overflow,
	// photodiode results
	input wire logic [9:0] bias_high_result,
	input wire logic [9:0] bias_low_result,
	input wire logic [9:0] switch_high_result,
	input wire logic [9:0] switch_low_result,
	input wire logic [9:0] background_value,
	input wire logic [9:0] photodiode_target,
	input wire logic [9:0] bias_check_result,
	input wire logic [9:0] switch_check_result,
	input wire logic check_strobe,
	// configuration
	input wire logic [2:0] overcurrent_limit_sel,
	input wire logic overcurrent_clamp_en,
	input wire logic [1:0] diffuser_check_sel,
	input wire logic bias_check_disable,
	input wire logic [1:0] switch_check_window_sel,
	input wire logic calib_fault_response,
	input wire logic [7:0] fixed_bias_code,
	input wire logic [7:0] fixed_switch_code,
	input wire logic global_reset_block,
	// software writes
	input wire logic status_dummy_wr,
	input wire logic global_reset_wr,
	input wire logic [7:0] global_reset_data,
	// outputs
	output logic laser_cutoff,
	output logic emergency_out_n,
	output logic [7:0] laser_bias_out,
	output logic [7:0] laser_switch_out,
	output logic [7:0] fault_status
);
	// ****************************************
	// state
	// ****************************************
	logic supply_cut_q;
	logic supply_cut_d;
	logic calib_fix_q;
	logic calib_fix_d;
	logic calib_cut_q;
	logic calib_cut_d;
	logic dif_cut_q;
	logic dif_cut_d;
	logic [4:0] flags_q;
	logic [4:0] flags_set;
	logic laser_cutoff_q;
	logic emergency_n_q;
	logic [7:0] bias_out_q;
	logic [7:0] switch_out_q;
	logic bias_fault;
	logic switch_fault;
	logic diffuser_fault;
	logic [8:0] oc_limit;
	logic [8:0] oc_sum;
	logic oc_now;
	logic clear_flags;
	logic global_clear;
	logic cut_d;
	logic [7:0] bias_eff;
	logic [7:0] clamp_switch;
	logic [7:0] clamp_bias;

	lfm_calib_check u_check (
		.bias_high_result(bias_high_result),
		.bias_low_result(bias_low_result),
		.switch_high_result(switch_high_result),
		.switch_low_result(switch_low_result),
		.background_value(background_value),
		.photodiode_target(photodiode_target),
		.bias_check_result(bias_check_result),
		.switch_check_result(switch_check_result),
		.bias_calc_overflow(bias_calc_overflow),
		.switch_calc_overflow(switch_calc_overflow),
		.threshold_negative(threshold_negative),
		.switch_code_negative(switch_code_negative),
		.diffuser_check_sel(diffuser_check_sel),
		.bias_check_disable(bias_check_disable),
		.switch_check_window_sel(switch_check_window_sel),
		.bias_fault(bias_fault),
		.switch_fault(switch_fault),
		.diffuser_fault(diffuser_fault)
	);

	// ****************************************
	// overcurrent detector
	// ****************************************
	always_comb begin
		case (overcurrent_limit_sel)
			3'h0: oc_limit = OC_LIMIT_0;
			3'h1: oc_limit = OC_LIMIT_1;
			3'h2: oc_limit = OC_LIMIT_2;
			3'h3: oc_limit = OC_LIMIT_3;
			3'h4: oc_limit = OC_LIMIT_4;
			3'h5: oc_limit = OC_LIMIT_5;
			default: oc_limit = OC_LIMIT_6;
		endcase
	end

	assign oc_sum = {3'h0, computed_bias_code[7:2]} + {1'h0, computed_switch_code};
	assign oc_now = (overcurrent_limit_sel != OVERCURRENT_LIMIT_SEL_OFF) && (oc_sum > oc_limit);

	// ****************************************
	// fault state
	// ****************************************
	always_comb begin
		supply_cut_d = supply_cut_q;
		if (supply_low) begin
			supply_cut_d = 1'b1;
		end else if (supply_high) begin
			supply_cut_d = 1'b0;
		end
	end

	always_comb begin
		calib_fix_d = calib_fix_q;
		calib_cut_d = calib_cut_q;
		dif_cut_d = dif_cut_q;
		if (global_clear) begin
			calib_fix_d = 1'b0;
			calib_cut_d = 1'b0;
			dif_cut_d = 1'b0;
		end
		if (check_strobe) begin
			calib_fix_d = (bias_fault || switch_fault) && calib_fault_response;
			calib_cut_d = (bias_fault || switch_fault) && !calib_fault_response;
			dif_cut_d = diffuser_fault;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			supply_cut_q <= 1'b0;
			calib_fix_q <= 1'b0;
			calib_cut_q <= 1'b0;
			dif_cut_q <= 1'b0;
		end else begin
			supply_cut_q <= supply_cut_d;
			calib_fix_q <= calib_fix_d;
			calib_cut_q <= calib_cut_d;
			dif_cut_q <= dif_cut_d;
		end
	end

	// ****************************************
	// sticky flags
	// ****************************************
	assign global_clear = global_reset_wr && (global_reset_data == GLOBAL_RESET_CMD)
		&& !global_reset_block;
	assign clear_flags = status_dummy_wr || global_clear;
	assign flags_set = {check_strobe && switch_fault, check_strobe && bias_fault,
		supply_low, check_strobe && diffuser_fault, oc_now};

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			flags_q <= FLAGS_RESET;
		end else if (clear_flags) begin
			flags_q <= flags_set;
		end else begin
			flags_q <= flags_q | flags_set;
		end
	end

	// ****************************************
	// drive and emergency outputs
	// ****************************************
	assign cut_d = supply_cut_d || (oc_now && !overcurrent_clamp_en)
		|| calib_cut_d || dif_cut_d;
	assign bias_eff = (threshold_negative && bias_check_disable) ? 8'h00 : computed_bias_code;
	assign clamp_switch = (oc_limit > {3'h0, bias_eff[7:2]})
		? 8'((oc_limit - {3'h0, bias_eff[7:2]}) > 9'h0FF ? 9'h0FF : (oc_limit - {3'h0, bias_eff[7:2]}))
		: 8'h00;
	assign clamp_bias = ({3'h0, bias_eff[7:2]} > oc_limit)
		? {oc_limit[5:0], 2'h3} : bias_eff;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			laser_cutoff_q <= 1'b0;
			emergency_n_q <= 1'b1;
		end else begin
			laser_cutoff_q <= cut_d;
			emergency_n_q <= !cut_d;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			bias_out_q <= 8'h00;
			switch_out_q <= 8'h00;
		end else if (calib_fix_d) begin
			bias_out_q <= fixed_bias_code;
			switch_out_q <= fixed_switch_code;
		end else if (oc_now && overcurrent_clamp_en) begin
			bias_out_q <= clamp_bias;
			switch_out_q <= clamp_switch;
		end else begin
			bias_out_q <= bias_eff;
			switch_out_q <= computed_switch_code;
		end
	end

	assign laser_cutoff = laser_cutoff_q;
	assign emergency_out_n = emergency_n_q;
	assign laser_bias_out = bias_out_q;
	assign laser_switch_out = switch_out_q;
	assign fault_status = {flags_q, VERSION_CODE};

	// ****************************************
	// assertions
	// ****************************************
	supply_cut_a: assert property (@(posedge clk) disable iff (!resetn)
		supply_low |=> laser_cutoff && !emergency_out_n)
		else $error("supply fault did not cut laser");
	supply_flag_a: assert property (@(posedge clk) disable iff (!resetn)
		supply_low |=> fault_status[FLAG_SUPPLY_BIT])
		else $error("supply flag not set");
	supply_release_a: assert property (@(posedge clk) disable iff (!resetn)
		supply_high && !supply_low && !oc_now && !calib_cut_d && !dif_cut_d
		|=> !laser_cutoff && emergency_out_n)
		else $error("cut-off not released on supply recovery");
	flag_sticky_a: assert property (@(posedge clk) disable iff (!resetn)
		fault_status[FLAG_SUPPLY_BIT] && !status_dummy_wr && !global_reset_wr
		|=> fault_status[FLAG_SUPPLY_BIT])
		else $error("sticky flag lost");
	flag_clear_a: assert property (@(posedge clk) disable iff (!resetn)
		status_dummy_wr && !supply_low && !oc_now && !check_strobe
		|=> fault_status[7:3] == 5'h00)
		else $error("dummy write did not clear flags");
	global_clear_a: assert property (@(posedge clk) disable iff (!resetn)
		global_reset_wr && global_reset_data == 8'h01 && global_reset_block
		&& fault_status[FLAG_OVERCURRENT_BIT] && !status_dummy_wr
		|=> fault_status[FLAG_OVERCURRENT_BIT])
		else $error("blocked global reset cleared flags");
	oc_cut_a: assert property (@(posedge clk) disable iff (!resetn)
		oc_now && !overcurrent_clamp_en
		|=> laser_cutoff && !emergency_out_n && fault_status[FLAG_OVERCURRENT_BIT])
		else $error("overcurrent did not cut laser");
	oc_limit_a: assert property (@(posedge clk) disable iff (!resetn)
		oc_now && overcurrent_clamp_en && !calib_fix_d
		|=> ({1'b0, laser_switch_out} + {3'h0, laser_bias_out[7:2]} <= $past(oc_limit))
		&& fault_status[FLAG_OVERCURRENT_BIT])
		else $error("clamp did not hold current at limit");
	oc_off_a: assert property (@(posedge clk) disable iff (!resetn)
		overcurrent_limit_sel == OVERCURRENT_LIMIT_SEL_OFF && status_dummy_wr
		|=> !fault_status[FLAG_OVERCURRENT_BIT])
		else $error("overcurrent flagged while disabled");
	calib_fix_a: assert property (@(posedge clk) disable iff (!resetn)
		check_strobe && (bias_fault || switch_fault) && calib_fault_response
		|=> laser_bias_out == $past(fixed_bias_code)
		&& laser_switch_out == $past(fixed_switch_code))
		else $error("fixed codes not driven on calibration fault");
	calib_cut_a: assert property (@(posedge clk) disable iff (!resetn)
		check_strobe && bias_fault && !calib_fault_response
		|=> !emergency_out_n && fault_status[FLAG_BIAS_BIT])
		else $error("calibration fault did not pull emergency");
endmodule : lfm_monitor

// file: test/lfm_laser_model.sv
// supply comparator model at the far side of the laser fault monitor
module lfm_laser_model (
	// supply level in millivolts
	input wire logic [11:0] supply_mv,
	// comparator outputs
	output logic supply_low,
	output logic supply_high
);
	timeunit 1ns;
	timeprecision 1ps;
	// ****************************************
	// hysteresis comparators
	// ****************************************
	assign supply_low = supply_mv < 12'h9C4;
	assign supply_high = supply_mv > 12'hA5A;
endmodule : lfm_laser_model

// file: test/laser_fault_monitor_bench.sv
// self-checking bench for the laser fault monitor
module laser_fault_monitor_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic supply_low, supply_high, threshold_negative, switch_code_negative;
	logic bias_calc_overflow, switch_calc_overflow, check_strobe, overcurrent_clamp_en;
	logic bias_check_disable, calib_fault_response, global_reset_block;
	logic status_dummy_wr, global_reset_wr, laser_cutoff, emergency_out_n;
	logic [7:0] computed_bias_code, computed_switch_code, fixed_bias_code, fixed_switch_code;
	logic [7:0] global_reset_data, laser_bias_out, laser_switch_out, fault_status;
	logic [9:0] bias_high_result, bias_low_result, switch_high_result, switch_low_result;
	logic [9:0] background_value, photodiode_target, bias_check_result, switch_check_result;
	logic [2:0] overcurrent_limit_sel;
	logic [1:0] diffuser_check_sel, switch_check_window_sel;
	logic [11:0] supply_mv;
	logic [31:0] seed = 32'h0000DD04;
	logic [8:0] lim [7] = '{9'h0E9, 9'h0C8, 9'h0A7, 9'h085, 9'h06B, 9'h050, 9'h035};
	int fails = 0;
	int compares = 0;
	int cycles = 0;
	always #5 clk = ~clk;
	lfm_laser_model u_far (.supply_mv, .supply_low, .supply_high);
	lfm_monitor u_dut (.clk, .resetn, .supply_low, .supply_high, .computed_bias_code,
		.computed_switch_code, .threshold_negative, .switch_code_negative,
		.bias_calc_overflow, .switch_calc_overflow, .bias_high_result, .bias_low_result,
		.switch_high_result, .switch_low_result, .background_value, .photodiode_target,
		.bias_check_result, .switch_check_result, .check_strobe, .overcurrent_limit_sel,
		.overcurrent_clamp_en, .diffuser_check_sel, .bias_check_disable,
		.switch_check_window_sel, .calib_fault_response, .fixed_bias_code, .fixed_switch_code,
		.global_reset_block, .status_dummy_wr, .global_reset_wr, .global_reset_data,
		.laser_cutoff, .emergency_out_n, .laser_bias_out, .laser_switch_out, .fault_status);
	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd
	task automatic tick();
		@(posedge clk);
		#1;
	endtask : tick
	task automatic chk(input logic [9:0] got, input logic [9:0] exp);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t got %0h exp %0h", $time, got, exp);
		end
	endtask : chk
	task automatic wrap_up();
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : wrap_up
	// ****************************************
	// overcurrent case
	// ****************************************
	task automatic oc_case(input logic [2:0] sel, input logic [7:0] b, input logic [7:0] s,
		input logic c);
		logic f;
		logic [9:0] cap;
		overcurrent_limit_sel = sel;
		computed_bias_code = b;
		computed_switch_code = s;
		overcurrent_clamp_en = c;
		status_dummy_wr = 1'b1;
		tick();
		status_dummy_wr = 1'b0;
		f = sel != 3'h7 && {3'h0, b[7:2]} + {1'b0, s} > lim[sel];
		cap = (sel != 3'h7 && lim[sel] >= b[7:2]) ? {1'b0, lim[sel] - b[7:2]} : 10'h000;
		chk(fault_status[3], f);
		chk(laser_cutoff, f & !c);
		chk(emergency_out_n, !(f & !c));
		if (f && c) chk(laser_switch_out, cap);
		computed_bias_code = 8'h00;
		computed_switch_code = 8'h00;
		tick();
		chk(fault_status[3], f);
		chk(laser_cutoff, 1'b0);
		chk(laser_switch_out, 10'h000);
	endtask : oc_case
	// ****************************************
	// calibration case
	// ****************************************
	task automatic cal_case();
		logic [31:0] r;
		logic bf, sf, df, cut;
		int bg, d;
		r = rnd();
		bias_low_result = {1'b0, r[8:0]};
		bias_high_result = {1'b0, r[8:0]} + {8'h00, r[10:9]};
		switch_low_result = {1'b0, r[19:11]};
		switch_high_result = {1'b0, r[19:11]} + {8'h00, r[21:20]};
		bias_calc_overflow = r[24:22] == 3'h0;
		switch_calc_overflow = r[27:25] == 3'h0;
		threshold_negative = r[30:28] == 3'h0;
		bias_check_disable = r[31];
		r = rnd();
		background_value = {2'h0, r[7:0]};
		photodiode_target = {2'h0, r[15:8]} + 10'h0B4;
		bias_check_result = {2'h0, r[7:0]} + {3'h0, r[22:16]} + 10'h010;
		switch_check_result = background_value + photodiode_target + 10'h050 - {1'b0, r[30:23], 1'b0};
		r = rnd();
		switch_code_negative = r[2:0] == 3'h0;
		diffuser_check_sel = r[4:3];
		switch_check_window_sel = r[6:5];
		calib_fault_response = r[7];
		fixed_bias_code = r[15:8];
		fixed_switch_code = r[23:16];
		check_strobe = 1'b1;
		status_dummy_wr = 1'b1;
		tick();
		check_strobe = 1'b0;
		status_dummy_wr = 1'b0;
		bg = int'(background_value);
		d = int'(switch_check_result) - int'(photodiode_target) - bg;
		if (d < 0) d = -d;
		bf = bias_high_result <= bias_low_result || bias_calc_overflow || !bias_check_disable
			&& (threshold_negative || int'(bias_check_result) > bg + int'(12'h040));
		sf = switch_high_result <= switch_low_result || switch_calc_overflow
			|| switch_check_window_sel != 2'h3
			&& (switch_code_negative || d > int'(12'h040 << switch_check_window_sel));
		df = diffuser_check_sel != 2'h3
			&& int'(switch_check_result) < bg + int'(12'h080 >> diffuser_check_sel);
		cut = df || (bf || sf) && !calib_fault_response;
		chk(fault_status[7], sf);
		chk(fault_status[6], bf);
		chk(fault_status[4], df);
		chk(laser_cutoff, cut);
		chk(emergency_out_n, !cut);
		if (!cut && (bf || sf)) begin
			chk(laser_bias_out, fixed_bias_code);
			chk(laser_switch_out, fixed_switch_code);
		end
		if (!(bf || sf || df) && bias_check_disable && threshold_negative) begin
			chk(laser_bias_out, 10'h000);
		end
		tick();
		chk(fault_status[7:3], {sf, bf, 1'b0, df, 1'b0});
		chk(laser_cutoff, cut);
	endtask : cal_case
	// ****************************************
	// main sequence
	// ****************************************
	always @(posedge clk) begin
		cycles++;
		if (cycles == 2000) begin
			fails++;
			wrap_up();
		end
	end
	initial begin
		logic [31:0] r;
		supply_mv = 12'hCE4;
		{threshold_negative, switch_code_negative, bias_calc_overflow, switch_calc_overflow,
			check_strobe, overcurrent_clamp_en, bias_check_disable, calib_fault_response,
			global_reset_block, status_dummy_wr, global_reset_wr} = 11'h000;
		{computed_bias_code, computed_switch_code, fixed_bias_code, fixed_switch_code,
			global_reset_data} = 40'h0;
		{bias_high_result, bias_low_result, switch_high_result, switch_low_result,
			background_value, photodiode_target, bias_check_result, switch_check_result} = 80'h0;
		overcurrent_limit_sel = 3'h7;
		diffuser_check_sel = 2'h3;
		switch_check_window_sel = 2'h3;
		repeat (8) @(posedge clk);
		#1 resetn = 1'b1;
		chk(fault_status, 10'h005);
		chk(laser_cutoff, 1'b0);
		chk(emergency_out_n, 1'b1);
		$display("reset test done");
		overcurrent_clamp_en = 1'b1;
		calib_fault_response = 1'b1;
		supply_mv = 12'h960;
		tick();
		chk(laser_cutoff, 1'b1);
		chk(emergency_out_n, 1'b0);
		chk(fault_status[5], 1'b1);
		supply_mv = 12'hA28;
		tick();
		chk(laser_cutoff, 1'b1);
		supply_mv = 12'hCE4;
		tick();
		chk(laser_cutoff, 1'b0);
		chk(emergency_out_n, 1'b1);
		chk(fault_status[5], 1'b1);
		global_reset_wr = 1'b1;
		global_reset_data = 8'h02;
		tick();
		chk(fault_status[5], 1'b1);
		global_reset_data = 8'h01;
		global_reset_block = 1'b1;
		tick();
		chk(fault_status[5], 1'b1);
		global_reset_block = 1'b0;
		tick();
		global_reset_wr = 1'b0;
		chk(fault_status, 10'h005);
		supply_mv = 12'h960;
		tick();
		supply_mv = 12'hCE4;
		tick();
		status_dummy_wr = 1'b1;
		tick();
		status_dummy_wr = 1'b0;
		chk(fault_status, 10'h005);
		tick();
		chk(fault_status, 10'h005);
		$display("supply and reset test done");
		oc_case(3'h0, 8'h00, 8'hE9, 1'b0);
		oc_case(3'h0, 8'h04, 8'hE9, 1'b0);
		oc_case(3'h6, 8'h04, 8'h35, 1'b1);
		oc_case(3'h7, 8'hFF, 8'hFF, 1'b0);
		for (int k = 0; k < 64; k++) begin
			r = rnd();
			oc_case(k[2:0], r[15:8], r[23:16], r[31]);
		end
		overcurrent_limit_sel = 3'h7;
		$display("overcurrent test done");
		repeat (80) cal_case();
		$display("calibration test done");
		wrap_up();
	end
endmodule : laser_fault_monitor_bench
